// File: common/iop_pkg.sv
// package: constants, states and carriers of the io processor decoder
package iop_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned MAJOR_NS = 500;
	localparam int unsigned MAJOR_CYC = (MAJOR_NS * CLK_MHZ) / 1000;
	localparam logic [6:0] TICK_MAX = 7'(MAJOR_CYC - 1);
	// ==========================================
	// instruction word fields and special addresses
	localparam int unsigned G_POS = 15;
	localparam int unsigned F_LSB = 6;
	localparam int unsigned S_POS = 5;
	localparam logic [11:0] ADDR_MAX = 12'hfff;
	localparam logic [11:0] LOC_ZERO = 12'h000;
	// ==========================================
	// function codes (low six opcode bits)
	localparam logic [5:0] F_PASS = 6'h00;
	localparam logic [5:0] F_LJM = 6'h01;
	localparam logic [5:0] F_RJM = 6'h02;
	localparam logic [5:0] F_NA_LO = 6'h03;
	localparam logic [5:0] F_NA_HI = 6'h0f;
	localparam logic [5:0] F_CN_LO = 6'h10;
	localparam logic [5:0] F_CN_HI = 6'h13;
	localparam logic [5:0] F_LDR = 6'h14;
	localparam logic [5:0] F_STR = 6'h15;
	localparam logic [5:0] F_XJ = 6'h16;
	localparam logic [5:0] F_RPN = 6'h17;
	localparam logic [5:0] F_DI_LO = 6'h18;
	localparam logic [5:0] F_ST_DI = 6'h1c;
	localparam logic [5:0] F_DI_HI = 6'h1f;
	localparam logic [5:0] F_IN_LO = 6'h20;
	localparam logic [5:0] F_ST_IN = 6'h24;
	localparam logic [5:0] F_IN_HI = 6'h27;
	localparam logic [5:0] F_ME_LO = 6'h28;
	localparam logic [5:0] F_ST_ME = 6'h2c;
	localparam logic [5:0] F_ME_HI = 6'h2f;
	localparam logic [5:0] F_CRD = 6'h30;
	localparam logic [5:0] F_CRDB = 6'h31;
	localparam logic [5:0] F_CWRB = 6'h33;
	localparam logic [5:0] F_CH_LO = 6'h34;
	localparam logic [5:0] F_CH_FL = 6'h35;
	localparam logic [5:0] F_CH_ER = 6'h37;
	localparam logic [5:0] F_IAM = 6'h39;
	localparam logic [5:0] F_OAM = 6'h3b;
	// ==========================================
	// channel commands
	localparam logic [2:0] CH_NONE = 3'h0;
	localparam logic [2:0] CH_LEGACY = 3'h1;
	localparam logic [2:0] CH_FLAG_SET = 3'h2;
	localparam logic [2:0] CH_FLAG_CLR = 3'h3;
	localparam logic [2:0] CH_ERR_CLR = 3'h4;
	// ==========================================
	// register offsets and reset values
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PADDR = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_OPND = 8'h0c;
	localparam logic [7:0] REG_RELOC = 8'h10;
	localparam logic [7:0] REG_CMA = 8'h14;
	localparam logic [11:0] P_RESET = 12'h000;
	localparam logic [27:0] REL_RESET = 28'h0000000;
	// ==========================================
	// state machine
	typedef enum logic [11:0] {
		S_IDLE = 12'h001,
		S_FETCH1 = 12'h002,
		S_FETCH2 = 12'h004,
		S_DECODE = 12'h008,
		S_OPB = 12'h010,
		S_OPC = 12'h020,
		S_EXEC = 12'h040,
		S_EXIT = 12'h080,
		S_EXIT2 = 12'h100,
		S_RLD1 = 12'h200,
		S_RLD2 = 12'h400,
		S_RST2 = 12'h800
	} state_t;
	// decoded instruction presented to the execution side
	typedef struct packed {
		logic [6:0] opcode;
		logic [17:0] operand;
		logic [11:0] ea;
		logic [4:0] chan;
		logic [2:0] chan_cmd;
		logic [27:0] central_addr;
		logic short_st;
		logic blk;
	} dec_t;
endpackage

// File: design/iop_decode.sv
// io processor instruction fetch, decode and operand address generation
`timescale 1ns/1ps
module iop_decode (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [11:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic [17:0] acc,
	input wire logic wb_valid,
	input wire logic [15:0] wb_data,
	input wire logic exec_done,
	output logic instr_valid,
	output iop_pkg::dec_t dec_out
);
	// ==========================================
	// state record
	typedef struct packed {
		iop_pkg::state_t state;
		logic run;
		logic [11:0] p;
		logic [15:0] ir1;
		logic [15:0] ir2;
		logic [27:0] rel;
		logic [6:0] tick_cnt;
		logic tick;
		logic rd_pend;
		logic [15:0] rdq;
		logic [11:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic [15:0] mem_wdata;
		iop_pkg::dec_t dec;
		logic exec;
		logic [31:0] reg_rdata;
		logic [7:0] cyc_cnt;
		logic [7:0] cyc_last;
	} st_t;

	st_t s_r;
	st_t s_nxt;

	// ==========================================
	// helpers
	// long formats carry a second word
	function automatic logic two_word(input logic [5:0] f);
		two_word = (f == iop_pkg::F_LJM) || (f == iop_pkg::F_RJM)
			|| (f >= iop_pkg::F_CN_LO && f <= iop_pkg::F_CN_HI)
			|| (f >= iop_pkg::F_ME_LO && f <= iop_pkg::F_ME_HI)
			|| (f == iop_pkg::F_CRDB) || (f == iop_pkg::F_CWRB)
			|| (f >= iop_pkg::F_CH_LO && f <= iop_pkg::F_CH_ER)
			|| (f == iop_pkg::F_IAM) || (f == iop_pkg::F_OAM);
	endfunction

	// indexed address with the boundary table applied
	function automatic logic [11:0] index_ea(input logic [11:0] m,
		input logic [11:0] idx);
		logic idx_in;
		idx_in = (idx != 12'h000) && (idx != iop_pkg::ADDR_MAX);
		if (m == 12'h000 || m == iop_pkg::ADDR_MAX) begin
			if (idx_in)
				index_ea = idx;
			else if (idx == iop_pkg::ADDR_MAX && m == iop_pkg::ADDR_MAX)
				index_ea = iop_pkg::ADDR_MAX;
			else
				index_ea = 12'h000;
		end else if (idx_in) begin
			index_ea = m + idx;
		end else begin
			index_ea = m;
		end
	endfunction

	// ==========================================
	// instruction fields
	logic g_bit;
	logic [5:0] f_fld;
	logic [5:0] d_fld;
	logic [4:0] c_fld;
	logic s_fld;
	logic [11:0] m_fld;
	logic long_fmt;
	logic short_st;
	logic blk_op;

	// unused word bits are never looked at
	// ignore unused bits
	always_comb begin
		g_bit = s_r.ir1[iop_pkg::G_POS];
		f_fld = s_r.ir1[iop_pkg::F_LSB +: 6];
		d_fld = s_r.ir1[5:0];
		c_fld = s_r.ir1[4:0];
		s_fld = s_r.ir1[iop_pkg::S_POS];
		m_fld = s_r.ir2[11:0];
		long_fmt = two_word(f_fld);
		short_st = !g_bit && ((f_fld == iop_pkg::F_RJM)
			|| (f_fld >= iop_pkg::F_ST_DI && f_fld <= iop_pkg::F_DI_HI)
			|| (f_fld >= iop_pkg::F_ST_IN && f_fld <= iop_pkg::F_IN_HI)
			|| (f_fld >= iop_pkg::F_ST_ME && f_fld <= iop_pkg::F_ME_HI)
			|| (f_fld == iop_pkg::F_CRD) || (f_fld == iop_pkg::F_CRDB));
		blk_op = (f_fld == iop_pkg::F_CRDB) || (f_fld == iop_pkg::F_CWRB)
			|| (f_fld == iop_pkg::F_IAM) || (f_fld == iop_pkg::F_OAM);
	end

	// ==========================================
	// next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.mem_rd = 1'b0;
		s_nxt.mem_wr = 1'b0;
		s_nxt.tick = 1'b0;
		s_nxt.reg_rdata = 32'h00000000;

		if (s_r.tick_cnt == iop_pkg::TICK_MAX) begin
			s_nxt.tick_cnt = 7'h00;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 7'h01;
		end

		// read data lands one cycle after the strobe
		s_nxt.rd_pend = s_r.mem_rd;
		if (s_r.rd_pend)
			s_nxt.rdq = mem_rdata;

		// register reads
		if (reg_rd) begin
			case (reg_addr)
				iop_pkg::REG_CTRL: s_nxt.reg_rdata = {31'h0, s_r.run};
				iop_pkg::REG_PADDR: s_nxt.reg_rdata = {20'h0, s_r.p};
				iop_pkg::REG_STAT: s_nxt.reg_rdata = {s_r.cyc_last,
					s_r.dec.opcode, 5'h0, s_r.state};
				iop_pkg::REG_OPND: s_nxt.reg_rdata = {14'h0,
					s_r.dec.operand};
				iop_pkg::REG_RELOC: s_nxt.reg_rdata = {4'h0, s_r.rel};
				iop_pkg::REG_CMA: s_nxt.reg_rdata = {4'h0,
					s_r.dec.central_addr};
				default: s_nxt.reg_rdata = 32'h00000000;
			endcase
		end

		// register writes; program address only while the sequencer is in S_IDLE
		if (reg_wr) begin
			if (reg_addr == iop_pkg::REG_CTRL)
				s_nxt.run = reg_wdata[0];
			if (reg_addr == iop_pkg::REG_PADDR && s_r.state == iop_pkg::S_IDLE)
				s_nxt.p = reg_wdata[11:0];
		end

		if (s_r.tick && s_r.state != iop_pkg::S_IDLE)
			s_nxt.cyc_cnt = s_r.cyc_cnt + 8'h01;

		case (s_r.state)
			iop_pkg::S_IDLE: begin
				if (s_r.tick && s_r.run) begin
					s_nxt.mem_addr = s_r.p;
					s_nxt.mem_rd = 1'b1;
					s_nxt.cyc_cnt = 8'h00;
					s_nxt.state = iop_pkg::S_FETCH1;
				end
			end
			iop_pkg::S_FETCH1: begin
				if (s_r.tick) begin
					s_nxt.ir1 = s_r.rdq;
					s_nxt.ir2 = 16'h0000;
					if (two_word(s_r.rdq[iop_pkg::F_LSB +: 6])) begin
						s_nxt.mem_addr = s_r.p + 12'h001;
						s_nxt.mem_rd = 1'b1;
						s_nxt.state = iop_pkg::S_FETCH2;
					end else begin
						s_nxt.state = iop_pkg::S_DECODE;
					end
				end
			end
			iop_pkg::S_FETCH2: begin
				if (s_r.tick) begin
					s_nxt.ir2 = s_r.rdq;
					s_nxt.state = iop_pkg::S_DECODE;
				end
			end
			iop_pkg::S_DECODE: begin
				if (s_r.tick) begin
					s_nxt.dec.opcode = {g_bit, f_fld};
					s_nxt.dec.operand = 18'h00000;
					s_nxt.dec.ea = 12'h000;
					s_nxt.dec.chan = 5'h00;
					s_nxt.dec.chan_cmd = iop_pkg::CH_NONE;
					s_nxt.dec.short_st = short_st;
					s_nxt.dec.blk = 1'b0;
					s_nxt.dec.central_addr = s_r.rel + {10'h000, acc};
					s_nxt.state = iop_pkg::S_EXEC;
					s_nxt.exec = 1'b1;
					if (f_fld == iop_pkg::F_PASS || f_fld == iop_pkg::F_RPN
						|| ((f_fld == iop_pkg::F_LDR || f_fld == iop_pkg::F_STR)
						&& d_fld == 6'h00)) begin
						s_nxt.exec = 1'b0;
						s_nxt.p = s_r.p + 12'h001;
						s_nxt.state = iop_pkg::S_IDLE;
					end else if (f_fld == iop_pkg::F_LDR) begin
						s_nxt.exec = 1'b0;
						s_nxt.mem_addr = {6'h00, d_fld};
						s_nxt.mem_rd = 1'b1;
						s_nxt.state = iop_pkg::S_RLD1;
					end else if (f_fld == iop_pkg::F_STR) begin
						s_nxt.exec = 1'b0;
						s_nxt.mem_addr = {6'h00, d_fld};
						s_nxt.mem_wdata = {4'h0, s_r.rel[27:16]};
						s_nxt.mem_wr = 1'b1;
						s_nxt.state = iop_pkg::S_RST2;
					end else if ((f_fld >= iop_pkg::F_NA_LO
						&& f_fld <= iop_pkg::F_NA_HI) || f_fld == iop_pkg::F_XJ) begin
						s_nxt.dec.operand = {12'h000, d_fld};
					end else if (f_fld >= iop_pkg::F_CN_LO
						&& f_fld <= iop_pkg::F_CN_HI) begin
						s_nxt.dec.operand = {d_fld, m_fld};
					end else if (f_fld >= iop_pkg::F_DI_LO
						&& f_fld <= iop_pkg::F_DI_HI) begin
						if (d_fld == 6'h00) begin
							s_nxt.dec.operand = 18'h00000;
						end else begin
							s_nxt.dec.ea = {6'h00, d_fld};
							s_nxt.mem_addr = {6'h00, d_fld};
							s_nxt.mem_rd = 1'b1;
							s_nxt.exec = 1'b0;
							s_nxt.state = iop_pkg::S_OPC;
						end
					end else if ((f_fld >= iop_pkg::F_ME_LO
						&& f_fld <= iop_pkg::F_ME_HI) || f_fld == iop_pkg::F_LJM
						|| f_fld == iop_pkg::F_RJM) begin
						s_nxt.exec = 1'b0;
						s_nxt.mem_rd = 1'b1;
						if (d_fld == 6'h00) begin
							s_nxt.dec.ea = m_fld;
							s_nxt.mem_addr = m_fld;
							s_nxt.state = iop_pkg::S_OPC;
						end else begin
							s_nxt.mem_addr = {6'h00, d_fld};
							s_nxt.state = iop_pkg::S_OPB;
						end
					end else if (f_fld >= iop_pkg::F_IN_LO
						&& f_fld <= iop_pkg::F_IN_HI) begin
						s_nxt.exec = 1'b0;
						s_nxt.mem_addr = {6'h00, d_fld};
						s_nxt.mem_rd = 1'b1;
						s_nxt.state = iop_pkg::S_OPB;
					end else begin
						// central and channel group
						s_nxt.dec.ea = long_fmt ? m_fld : {6'h00, d_fld};
						s_nxt.dec.operand = {12'h000, d_fld};
						if (f_fld >= iop_pkg::F_CH_LO) begin
							s_nxt.dec.chan = c_fld;
							s_nxt.dec.chan_cmd = iop_pkg::CH_LEGACY;
						end
						if (f_fld >= iop_pkg::F_CH_LO && f_fld <= iop_pkg::F_CH_ER
							&& s_fld) begin
							if (f_fld == iop_pkg::F_CH_LO)
								s_nxt.dec.chan_cmd = iop_pkg::CH_FLAG_SET;
							else if (f_fld == iop_pkg::F_CH_FL)
								s_nxt.dec.chan_cmd = iop_pkg::CH_FLAG_CLR;
							else
								s_nxt.dec.chan_cmd = iop_pkg::CH_ERR_CLR;
						end
						if (blk_op) begin
							s_nxt.mem_addr = iop_pkg::LOC_ZERO;
							s_nxt.mem_wdata = {4'h0, s_r.p + 12'h001};
							s_nxt.mem_wr = 1'b1;
							s_nxt.dec.blk = 1'b1;
							s_nxt.p = m_fld;
						end
					end
				end
			end
			iop_pkg::S_OPB: begin
				if (s_r.tick) begin
					if (f_fld >= iop_pkg::F_IN_LO && f_fld <= iop_pkg::F_IN_HI) begin
						s_nxt.dec.ea = s_r.rdq[11:0];
					end else begin
						s_nxt.dec.ea = index_ea(m_fld, s_r.rdq[11:0]);
					end
					s_nxt.mem_addr = (f_fld >= iop_pkg::F_IN_LO
						&& f_fld <= iop_pkg::F_IN_HI) ? s_r.rdq[11:0]
						: index_ea(m_fld, s_r.rdq[11:0]);
					s_nxt.mem_rd = 1'b1;
					s_nxt.state = iop_pkg::S_OPC;
				end
			end
			iop_pkg::S_OPC: begin
				if (s_r.tick) begin
					s_nxt.dec.operand = g_bit ? {2'h0, s_r.rdq}
						: {6'h00, s_r.rdq[11:0]};
					s_nxt.exec = 1'b1;
					s_nxt.state = iop_pkg::S_EXEC;
				end
			end
			iop_pkg::S_EXEC: begin
				if (wb_valid) begin
					s_nxt.mem_wr = 1'b1;
					s_nxt.mem_addr = s_r.dec.blk ? s_r.p : s_r.dec.ea;
					s_nxt.mem_wdata = s_r.dec.short_st ? {4'h0, wb_data[11:0]}
						: wb_data;
					if (s_r.dec.blk)
						s_nxt.p = s_r.p + 12'h001;
				end
				if (exec_done) begin
					s_nxt.exec = 1'b0;
					if (s_r.dec.blk) begin
						s_nxt.state = iop_pkg::S_EXIT;
					end else begin
						s_nxt.p = s_r.p + (long_fmt ? 12'h002 : 12'h001);
						s_nxt.cyc_last = s_r.cyc_cnt;
						s_nxt.state = iop_pkg::S_IDLE;
					end
				end
			end
			iop_pkg::S_EXIT: begin
				if (s_r.tick) begin
					s_nxt.mem_addr = iop_pkg::LOC_ZERO;
					s_nxt.mem_rd = 1'b1;
					s_nxt.state = iop_pkg::S_EXIT2;
				end
			end
			iop_pkg::S_EXIT2: begin
				if (s_r.tick) begin
					s_nxt.p = s_r.rdq[11:0] + 12'h001;
					s_nxt.cyc_last = s_r.cyc_cnt;
					s_nxt.state = iop_pkg::S_IDLE;
				end
			end
			iop_pkg::S_RLD1: begin
				if (s_r.tick) begin
					s_nxt.rel[27:16] = s_r.rdq[11:0];
					s_nxt.mem_addr = {6'h00, d_fld + 6'h01};
					s_nxt.mem_rd = 1'b1;
					s_nxt.state = iop_pkg::S_RLD2;
				end
			end
			iop_pkg::S_RLD2: begin
				if (s_r.tick) begin
					s_nxt.rel[15:0] = s_r.rdq;
					s_nxt.p = s_r.p + 12'h001;
					s_nxt.cyc_last = s_r.cyc_cnt;
					s_nxt.state = iop_pkg::S_IDLE;
				end
			end
			iop_pkg::S_RST2: begin
				if (s_r.tick) begin
					s_nxt.mem_addr = {6'h00, d_fld + 6'h01};
					s_nxt.mem_wdata = s_r.rel[15:0];
					s_nxt.mem_wr = 1'b1;
					s_nxt.p = s_r.p + 12'h001;
					s_nxt.cyc_last = s_r.cyc_cnt;
					s_nxt.state = iop_pkg::S_IDLE;
				end
			end
			default: begin
				s_nxt.state = iop_pkg::S_IDLE;
				s_nxt.exec = 1'b0;
			end
		endcase
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.state <= iop_pkg::S_IDLE;
			s_r.p <= iop_pkg::P_RESET;
			s_r.rel <= iop_pkg::REL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// outputs straight from the state record
	assign reg_rdata = s_r.reg_rdata;
	assign mem_addr = s_r.mem_addr;
	assign mem_rd = s_r.mem_rd;
	assign mem_wr = s_r.mem_wr;
	assign mem_wdata = s_r.mem_wdata;
	assign instr_valid = s_r.exec;
	assign dec_out = s_r.dec;
endmodule // iop_decode

// File: bench/local_mem_model.sv
// local word memory model facing the decoder
`timescale 1ns/1ps
module local_mem_model (
	input wire logic sys_clk,
	input wire logic [11:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [4096];
	// clear the array so fetches never see unknown words
	initial begin
		mem_rdata = 16'h0000;
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	// write port; read data stands only in the cycle after a read
	always @(posedge sys_clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_rd) begin
			mem_rdata <= mem[mem_addr];
		end else begin
			mem_rdata <= ~mem_rdata; // stale data must not look valid
		end
	end
endmodule // local_mem_model

// File: bench/iop_decode_sva.sv
// checker: port assertions of the io processor decoder
`timescale 1ns/1ps
module iop_decode_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic instr_valid,
	input wire iop_pkg::dec_t dec_out
);
	logic [6:0] gap_r;
	logic seen_r;
	logic rdd_r;
	logic [15:0] last_r;
	// ==========================================
	// helpers: read spacing and last word returned
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gap_r <= 7'h00;
			seen_r <= 1'b0;
			rdd_r <= 1'b0;
		end else begin
			gap_r <= (mem_rd || gap_r == 7'h7c) ? 7'h00 : gap_r + 7'h01;
			seen_r <= seen_r | mem_rd;
			rdd_r <= mem_rd;
		end
		if (rdd_r) begin
			last_r <= mem_rdata;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// assertions
	property p_tick_gap;
		mem_rd && seen_r |-> gap_r == 7'h7c;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("memory read off the major cycle");
	property p_rpn_pass;
		$rose(instr_valid) |-> dec_out.opcode != 7'h17;
	endproperty
	a_rpn_pass: assert property (p_rpn_pass)
		else $error("program address read not run as a pass");
	property p_noaddr;
		$rose(instr_valid) && dec_out.opcode[5:0] inside {[iop_pkg::F_NA_LO:iop_pkg::F_NA_HI]}
			|-> dec_out.operand[17:6] == 12'h000;
	endproperty
	a_noaddr: assert property (p_noaddr)
		else $error("no-address operand wider than six bits");
	property p_width;
		$rose(instr_valid) && !dec_out.opcode[6] && dec_out.opcode[5:0] inside {6'h18, 6'h20, 6'h28}
			|-> dec_out.operand[17:12] == 6'h00;
	endproperty
	a_width: assert property (p_width)
		else $error("short load operand wider than twelve bits");
	property p_direct;
		$rose(instr_valid) && dec_out.opcode == 7'h18 && dec_out.ea != 12'h000
			|-> dec_out.operand == {6'h00, last_r[11:0]};
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct operand differs from word read");
	property p_dzero;
		$rose(instr_valid) && dec_out.opcode[5:0] == 6'h18 && dec_out.ea == 12'h000
			|-> dec_out.operand == 18'h00000;
	endproperty
	a_dzero: assert property (p_dzero)
		else $error("direct reference to location zero not zero");
	property p_indirect;
		$rose(instr_valid) && dec_out.opcode == 7'h60 |-> dec_out.operand == {2'h0, last_r};
	endproperty
	a_indirect: assert property (p_indirect)
		else $error("indirect operand differs from final word read");
	property p_short_st;
		mem_wr && instr_valid && dec_out.short_st |-> mem_wdata[15:12] == 4'h0;
	endproperty
	a_short_st: assert property (p_short_st)
		else $error("short store kept upper bits");
endmodule // iop_decode_sva

bind iop_decode iop_decode_sva chk (.sys_clk(sys_clk), .rst_n(rst_n), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
	.instr_valid(instr_valid), .dec_out(dec_out));

// File: bench/iop_decode_bench.sv
// testbench of the io processor decoder
`timescale 1ns/1ps
module iop_decode_bench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [11:0] mem_addr;
	logic mem_rd, mem_wr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [17:0] acc = 18'h21234;
	logic wb_valid = 1'b0;
	logic [15:0] wb_data = 16'h0;
	logic exec_done = 1'b0;
	logic instr_valid;
	iop_pkg::dec_t dec_out;
	logic [31:0] rd;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2 sys_clk = ~sys_clk;
	iop_decode uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .acc(acc), .wb_valid(wb_valid), .wb_data(wb_data),
		.exec_done(exec_done), .instr_valid(instr_valid), .dec_out(dec_out));
	local_mem_model lm (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	// ==========================================
	// shared tasks
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(logic [7:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask
	task automatic await(ref logic s, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (s !== 1'b1 && n < lim);
		if (n >= lim) chk("wait", 32'h1, 32'h0);
	endtask
	// one-cycle completion strobe from the execution side
	task automatic done_pulse();
		@(posedge sys_clk);
		exec_done <= 1'b1;
		@(posedge sys_clk);
		exec_done <= 1'b0;
	endtask
	// write-back word and its strobe launched on the same edge
	task automatic wb(logic [15:0] d);
		@(posedge sys_clk);
		wb_data <= d;
		wb_valid <= 1'b1;
		@(posedge sys_clk);
		wb_valid <= 1'b0;
	endtask
	function automatic logic [15:0] iw(logic [6:0] op, logic [5:0] d);
		return {op[6], 3'h0, op[5:0], d};
	endfunction
	// place an instruction, start one fetch, then stop further fetches
	task automatic go(logic [11:0] pc, logic [15:0] w1, logic [15:0] w2);
		lm.mem[pc] = w1;
		lm.mem[pc + 12'h001] = w2;
		wr(iop_pkg::REG_PADDR, {20'h0, pc});
		wr(iop_pkg::REG_CTRL, 32'h1);
		await(mem_rd, 300);
		wr(iop_pkg::REG_CTRL, 32'h0);
	endtask
	// finish the instruction and wait for the sequencer to idle
	task automatic idle();
		int n;
		n = 0;
		do begin
			if (instr_valid === 1'b1) done_pulse();
			rdr(iop_pkg::REG_STAT);
			n++;
		end while (rd[11:0] !== 12'h001 && n < 600);
		if (n >= 600) chk("idle", 32'h1, 32'h0);
	endtask
	task automatic pchk(logic [11:0] e);
		rdr(iop_pkg::REG_PADDR);
		chk("paddr", {20'h0, e}, rd);
	endtask
	task automatic op_chk(string nm, logic [17:0] e);
		await(instr_valid, 1000);
		chk(nm, {14'h0, e}, {14'h0, dec_out.operand});
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs();
		rdr(iop_pkg::REG_STAT);
		chk("stat", 32'h1, rd);
		rdr(iop_pkg::REG_RELOC);
		chk("reloc", 32'h0, rd);
		rdr(8'h20);
		chk("unmapped", 32'h0, rd);
		$display("test regs done");
	endtask
	task automatic t_direct();
		lm.mem[5] = 16'hf123;
		lm.mem[0] = 16'h0777;
		for (int g = 0; g < 2; g++) begin
			go(12'h010, iw({g[0], 6'h18}, 6'h05), 16'h0);
			op_chk("direct", g ? 18'h0f123 : 18'h00123);
			chk("opcode", {25'h0, g[0], 6'h18}, {25'h0, dec_out.opcode});
			idle();
			pchk(12'h011);
		end
		go(12'h010, iw(7'h18, 6'h00), 16'h0);
		op_chk("direct zero", 18'h0);
		idle();
		go(12'h020, iw(7'h10, 6'h3f), 16'h0abc);
		op_chk("constant", 18'h3fabc);
		rdr(iop_pkg::REG_OPND);
		chk("operand reg", 32'h0003fabc, rd);
		idle();
		pchk(12'h022);
		go(12'h030, iw(7'h0c, 6'h2a) | 16'h7000, 16'h0);
		op_chk("no address", 18'h0002a);
		idle();
		$display("test immediate and direct done");
	endtask
	task automatic t_mem();
		logic [11:0] xv [8] = '{12'h000, 12'h000, 12'h000, 12'hfff, 12'hfff, 12'hfff,
			12'h010, 12'h010};
		logic [11:0] mv [8] = '{12'h345, 12'hfff, 12'h100, 12'hfff, 12'h000, 12'h200,
			12'hfff, 12'h020};
		logic [11:0] ev [8] = '{12'h345, 12'h000, 12'h100, 12'hfff, 12'h000, 12'h200,
			12'h010, 12'h030};
		lm.mem[7] = 16'h0300;
		lm.mem[12'h300] = 16'hbeef;
		go(12'h038, iw(7'h60, 6'h07), 16'h0);
		op_chk("indirect", 18'h0beef);
		idle();
		for (int i = 0; i < 8; i++) begin
			lm.mem[1] = {4'h0, xv[i]};
			go(12'h040, iw(7'h28, i == 0 ? 6'h00 : 6'h01), {4'h0, mv[i]});
			await(instr_valid, 1000);
			chk("indexed ea", {20'h0, ev[i]}, {20'h0, dec_out.ea});
			idle();
		end
		$display("test memory mode done");
	endtask
	task automatic t_store();
		for (int g = 0; g < 2; g++) begin
			go(12'h050, iw({g[0], 6'h1c}, 6'h06), 16'h0);
			await(instr_valid, 1000);
			chk("short st", g ? 32'h0 : 32'h1, {31'h0, dec_out.short_st});
			wb(16'hffff);
			idle();
			chk("store", g ? 32'hffff : 32'h0fff, {16'h0, lm.mem[6]});
		end
		go(12'h080, iw(7'h31, 6'h02), 16'h0100);
		await(instr_valid, 1000);
		// the location zero write lands one edge after decode
		@(posedge sys_clk);
		#1;
		chk("save loc0", 32'h81, {16'h0, lm.mem[0]});
		chk("blk", 32'h1, {31'h0, dec_out.blk});
		wb(16'hf111);
		wb(16'hf222);
		lm.mem[0] = 16'h0200;
		idle();
		chk("block words", 32'h01110222, {lm.mem[12'h100], lm.mem[12'h101]});
		pchk(12'h201);
		$display("test stores and block done");
	endtask
	task automatic t_reloc();
		logic [5:0] fv [5] = '{6'h34, 6'h34, 6'h35, 6'h36, 6'h37};
		logic [2:0] cv [5] = '{iop_pkg::CH_FLAG_SET, iop_pkg::CH_LEGACY,
			iop_pkg::CH_FLAG_CLR, iop_pkg::CH_ERR_CLR, iop_pkg::CH_ERR_CLR};
		go(12'h0a0, iw(7'h14, 6'h00), 16'h0);
		idle();
		pchk(12'h0a1);
		go(12'h0a8, iw(7'h17, 6'h00), 16'h0);
		idle();
		pchk(12'h0a9);
		lm.mem[4] = 16'h0abc;
		lm.mem[5] = 16'h5678;
		go(12'h0b0, iw(7'h14, 6'h04), 16'h0);
		idle();
		rdr(iop_pkg::REG_RELOC);
		chk("reloc", 32'h0abc5678, rd);
		go(12'h0b8, iw(7'h30, 6'h03), 16'h0);
		await(instr_valid, 1000);
		chk("central addr", 32'h0abc5678 + 32'h21234, {4'h0, dec_out.central_addr});
		rdr(iop_pkg::REG_CMA);
		chk("central reg", 32'h0abc5678 + 32'h21234, rd);
		idle();
		go(12'h0c0, iw(7'h15, 6'h08), 16'h0);
		idle();
		chk("reloc store", 32'h0abc5678, {lm.mem[8], lm.mem[9]});
		for (int i = 0; i < 5; i++) begin
			go(12'h0d0, iw({1'b0, fv[i]}, {i != 1, 5'h05}), 16'h0123);
			await(instr_valid, 1000);
			chk("chan cmd", {29'h0, cv[i]}, {29'h0, dec_out.chan_cmd});
			chk("chan", 32'h5, {27'h0, dec_out.chan});
			idle();
		end
		$display("test relocation and channel done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// cycle ceiling against a hung sequencer
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			$display("[FAIL] run time expected below ceiling seen %0d", cyc);
			complete_run();
		end
	end
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_direct();
		t_mem();
		t_store();
		t_reloc();
		complete_run();
	end
endmodule // iop_decode_bench
